/* File: hdl/bcc_map.svh */
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH
// register indexes; byte address is four times the index
`define BCC_IDX_CTRL 3'h2
`define BCC_IDX_STAT 3'h3
`define BCC_IDX_OPT 3'h4
// control register fields
`define BCC_C_ON 7
`define BCC_C_IRQ 6
`define BCC_C_MST 5
`define BCC_C_TX 4
`define BCC_C_ACK 3
`define BCC_C_REPEAT_START_REQUEST 2
`define BCC_C_WAKE 1
`define BCC_CTRL_RST 8'h00
// status register fields
`define BCC_S_ADDRESSED_AS_SLAVE_FLAG 6
`define BCC_S_BUSY 5
`define BCC_S_ARBITRATION_LOST_FLAG 4
`define BCC_S_SRW 2
`define BCC_S_MMODE 0
// option register fields
`define BCC_O_EACK 0
`define BCC_OPT_RST 8'h00
// bus answers
`define BCC_RESP_OKAY 2'h0
`define BCC_RESP_SLVERR 2'h2
// timing
`define BCC_CLK_NS 4
`define BCC_PHASE_NS 2500
`define BCC_PHASE_CYC ((`BCC_PHASE_NS + `BCC_CLK_NS - 1) / `BCC_CLK_NS)
`endif

/* File: hdl/bcc_pkg.sv */
`include "bcc_map.svh"
package bcc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_HI,
    ST_START_LO,
    ST_MASTER,
    ST_RS_SDA,
    ST_RS_SCL,
    ST_STOP_LO,
    ST_STOP_SCL,
    ST_STOP_SDA
  } bcc_state_t;

  typedef logic [2:0] bcc_idx_t;

  function automatic logic bcc_reg_hit(input logic [7:0] addr);
    bcc_idx_t idx;
    idx = addr[4:2];
    return (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0) &&
           (idx == `BCC_IDX_CTRL || idx == `BCC_IDX_STAT || idx == `BCC_IDX_OPT);
  endfunction : bcc_reg_hit
endpackage : bcc_pkg

/* File: hdl/bcc_sync.sv */
module bcc_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic aclk, // module clock
  input wire logic aresetn, // sync reset, low
  input wire logic [W-1:0] d, // async levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : bcc_sync

/* File: hdl/bcc_axil.sv */
`include "bcc_map.svh"
module bcc_axil
  import bcc_pkg::*;
(
  input wire logic aclk, // module clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write answer
  output logic bvalid, // write answer valid
  input wire logic bready, // write answer ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read answer
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic wr_en, // one-cycle write pulse
  output bcc_idx_t wr_idx, // write register index
  output logic [7:0] wr_data, // write low byte
  output logic wr_lane0, // low byte enabled
  output bcc_idx_t rd_idx, // read register index
  input wire logic [31:0] rd_word // read word for rd_idx
);
  logic [7:0] aw_addr_r;
  logic aw_got_r;
  logic w_got_r;
  logic rd_pend_r;
  logic rd_hit_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_addr_r <= 8'h00;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wr_data <= 8'h00;
      wr_lane0 <= 1'b0;
      wr_en <= 1'b0;
      wr_idx <= 3'h0;
      bvalid <= 1'b0;
      bresp <= `BCC_RESP_OKAY;
    end else begin
      wr_en <= 1'b0;
      if (awvalid && awready) begin
        aw_addr_r <= awaddr;
        aw_got_r <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata[7:0];
        wr_lane0 <= wstrb[0];
        w_got_r <= 1'b1;
        wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid <= 1'b1;
        wr_en <= bcc_reg_hit(aw_addr_r);
        wr_idx <= aw_addr_r[4:2];
        bresp <= bcc_reg_hit(aw_addr_r) ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_idx <= 3'h0;
      rd_pend_r <= 1'b0;
      rd_hit_r <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `BCC_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rd_idx <= araddr[4:2];
        rd_hit_r <= bcc_reg_hit(araddr);
        rd_pend_r <= 1'b1;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_hit_r ? rd_word : 32'h0000_0000;
        rresp <= rd_hit_r ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : bcc_axil

/* File: hdl/bcc_ctrl.sv */
// Our own choice: the AXI4-Lite interface to the registers.
`include "bcc_map.svh"
// Behaviour
// - control bit 7 enables the whole module; 0 keeps it inert
// - control bit 6 lets interrupt requests out; 0 suppresses them
// - master select rising drives a START and enters master mode
// - master select falling drives a STOP and returns to slave mode
// - bit 4 selects direction: 0 receive, 1 transmit
// - bit 3 is the SDA level in receive acknowledge slots
// - early ack option clear: next byte; set: current byte
// - SCL held low after a received byte until control written
// - writing bit 2 issues repeated START, only while current master and no byte is active
// - repeated START bit self-clears and always reads 0
// - repeated START at an improper point counts as arbitration loss
// - wake bit set: address match in low power wakes processor
// - wake bit clear: no interrupt on address match in low power
// - control bit 0 reserved, reads 0
// - arbitration loss sets sticky flag, cleared by writing 1
// - any control register write clears addressed-as-slave flag
// - bus busy set on detected START, cleared on detected STOP
module bcc_ctrl
  import bcc_pkg::*;
#(
  parameter int unsigned PHASE_CYC = `BCC_PHASE_CYC
) (
  input wire logic aclk, // module clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write answer
  output logic bvalid, // write answer valid
  input wire logic bready, // write answer ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read answer
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic scl_in, // clock pin level
  input wire logic sda_in, // data pin level
  output logic scl_oe, // pull clock pin low
  output logic sda_oe, // pull data pin low
  input wire logic arb_lost_in, // arbitration lost pulse from shifter
  input wire logic addr_match_in, // slave address match pulse
  input wire logic slave_rw_in, // slave read/write indication
  input wire logic ack_slot_in, // acknowledge bit time, level
  input wire logic rx_byte_done_in, // received byte complete pulse
  input wire logic byte_active_in, // byte or ack in progress
  input wire logic xfer_done_in, // transfer complete flag level
  input wire logic low_power_in, // processor in low power mode
  output logic irq_req, // interrupt request
  output logic wake_req, // wake request to processor
  output logic master_mode, // block owns the bus
  output logic tx_mode // transmit direction
);
  if (PHASE_CYC < 2) begin : g_bad_phase
    $error("PHASE_CYC must be at least 2");
  end
  localparam int CW = $clog2(PHASE_CYC + 1);
  localparam logic [7:0] CTRL_RST = `BCC_CTRL_RST;
  logic wr_en, wr_lane0;
  bcc_idx_t wr_idx, rd_idx;
  logic [7:0] wr_data;
  logic [31:0] rd_word;
  bcc_axil u_axil (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .wr_lane0(wr_lane0),
    .rd_idx(rd_idx), .rd_word(rd_word)
  );
  logic [1:0] bus_s, bus_p_r;
  bcc_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .aclk(aclk), .aresetn(aresetn), .d({scl_in, sda_in}), .q(bus_s)
  );
  logic module_on_r, irq_on_r, master_select_r, tx_r, ack_level_r, wake_r, early_ack_r;
  logic arbitration_lost_flag_r, addressed_as_slave_flag_r, busy_r, srw_r, stretch_r, ack_hold_r, ack_slot_p_r, ms_prev_r;
  bcc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  logic any_ctrl_wr, wr_ctrl, repeat_start_request_req, repeat_start_request_ok, repeat_start_request_bad, arb_evt;
  logic start_det, stop_det, phase_done, ack_used, drv_sda, drv_scl;

  assign any_ctrl_wr = wr_en && wr_idx == `BCC_IDX_CTRL;
  assign wr_ctrl = any_ctrl_wr && wr_lane0;
  assign repeat_start_request_req = wr_ctrl && wr_data[`BCC_C_REPEAT_START_REQUEST] && module_on_r;
  assign repeat_start_request_ok = repeat_start_request_req && state_r == ST_MASTER && !byte_active_in;
  assign repeat_start_request_bad = repeat_start_request_req && !repeat_start_request_ok;
  assign arb_evt = module_on_r && (arb_lost_in || repeat_start_request_bad);
  // sda falls or rises while scl stays high
  assign start_det = bus_p_r[1] && bus_s[1] && bus_p_r[0] && !bus_s[0];
  assign stop_det = bus_p_r[1] && bus_s[1] && !bus_p_r[0] && bus_s[0];
  assign phase_done = cnt_r == CW'(PHASE_CYC - 1);
  assign ack_used = early_ack_r ? ack_level_r : ack_hold_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_p_r <= 2'h3;
    end else begin
      bus_p_r <= bus_s;
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_on_r <= CTRL_RST[`BCC_C_ON];
      irq_on_r <= 1'b0;
      master_select_r <= 1'b0;
      tx_r <= 1'b0;
      ack_level_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        module_on_r <= wr_data[`BCC_C_ON];
        irq_on_r <= wr_data[`BCC_C_IRQ];
        master_select_r <= wr_data[`BCC_C_MST] && wr_data[`BCC_C_ON];
        tx_r <= wr_data[`BCC_C_TX];
        ack_level_r <= wr_data[`BCC_C_ACK];
        wake_r <= wr_data[`BCC_C_WAKE];
      end
      // lost bus drops master mode without a stop
      if (arb_evt) begin
        master_select_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      early_ack_r <= 1'b0;
    end else if (wr_en && wr_idx == `BCC_IDX_OPT && wr_lane0) begin
      early_ack_r <= wr_data[`BCC_O_EACK];
    end
  end

  // status flags; hardware set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arbitration_lost_flag_r <= 1'b0;
      addressed_as_slave_flag_r <= 1'b0;
      busy_r <= 1'b0;
      srw_r <= 1'b0;
    end else begin
      if (arb_evt) begin
        arbitration_lost_flag_r <= 1'b1;
      end else if (wr_en && wr_idx == `BCC_IDX_STAT && wr_lane0 && wr_data[`BCC_S_ARBITRATION_LOST_FLAG]) begin
        arbitration_lost_flag_r <= 1'b0;
      end
      if (module_on_r && addr_match_in) begin
        addressed_as_slave_flag_r <= 1'b1;
        srw_r <= slave_rw_in;
      end else if (any_ctrl_wr) begin
        addressed_as_slave_flag_r <= 1'b0;
      end
      if (!module_on_r || stop_det) begin
        busy_r <= 1'b0;
      end else if (start_det) begin
        busy_r <= 1'b1;
      end
    end
  end

  // acknowledge level and clock stretch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_hold_r <= 1'b0;
      ack_slot_p_r <= 1'b0;
      stretch_r <= 1'b0;
    end else begin
      ack_slot_p_r <= ack_slot_in;
      // late option: value latched after each slot serves the next byte
      if (ack_slot_p_r && !ack_slot_in) begin
        ack_hold_r <= ack_level_r;
      end
      if (module_on_r && rx_byte_done_in && !tx_r) begin
        stretch_r <= 1'b1;
      end else if (wr_ctrl || !module_on_r) begin
        stretch_r <= 1'b0;
      end
    end
  end

  // start, repeated start and stop sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (master_select_r && !ms_prev_r) state_nxt = ST_START_HI;
      ST_START_HI: if (phase_done) state_nxt = ST_START_LO;
      ST_START_LO: if (phase_done) state_nxt = ST_MASTER;
      ST_MASTER: begin
        // level test: a drop during the start phases still ends in a stop
        if (!master_select_r && !arb_evt) begin
          state_nxt = ST_STOP_LO;
        end else if (repeat_start_request_ok) begin
          state_nxt = ST_RS_SDA;
        end
      end
      ST_RS_SDA: if (phase_done) state_nxt = ST_RS_SCL;
      ST_RS_SCL: if (phase_done) state_nxt = ST_START_HI;
      ST_STOP_LO: if (phase_done) state_nxt = ST_STOP_SCL;
      ST_STOP_SCL: if (phase_done) state_nxt = ST_STOP_SDA;
      ST_STOP_SDA: if (phase_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (!module_on_r || arb_evt) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      ms_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ms_prev_r <= master_select_r;
      if (state_nxt != state_r || phase_done) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  always_comb begin
    drv_sda = 1'b0;
    drv_scl = 1'b0;
    case (state_r)
      ST_START_HI: drv_sda = 1'b1;
      ST_START_LO, ST_STOP_LO: begin
        drv_sda = 1'b1;
        drv_scl = 1'b1;
      end
      ST_RS_SDA: drv_scl = 1'b1;
      ST_STOP_SCL: drv_sda = 1'b1;
      default: begin
        drv_sda = 1'b0;
        drv_scl = 1'b0;
      end
    endcase
  end

  // pin drivers and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      master_mode <= 1'b0;
      tx_mode <= 1'b0;
    end else begin
      sda_oe <= module_on_r && (drv_sda || (ack_slot_in && !tx_r && !ack_used));
      scl_oe <= module_on_r && (drv_scl || stretch_r);
      master_mode <= state_r != ST_IDLE;
      tx_mode <= tx_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq_req <= module_on_r && irq_on_r && (arbitration_lost_flag_r || xfer_done_in ||
                 (addressed_as_slave_flag_r && !(low_power_in && !wake_r)));
      if (module_on_r && wake_r && low_power_in && addr_match_in) begin
        wake_req <= 1'b1;
      end else if (!low_power_in) begin
        wake_req <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      `BCC_IDX_CTRL: rd_word[7:0] = {module_on_r, irq_on_r, master_select_r, tx_r,
                                     ack_level_r, 1'b0, wake_r, 1'b0};
      `BCC_IDX_STAT: begin
        rd_word[`BCC_S_ADDRESSED_AS_SLAVE_FLAG] = addressed_as_slave_flag_r;
        rd_word[`BCC_S_BUSY] = busy_r;
        rd_word[`BCC_S_ARBITRATION_LOST_FLAG] = arbitration_lost_flag_r;
        rd_word[`BCC_S_SRW] = srw_r;
        rd_word[`BCC_S_MMODE] = master_mode;
      end
      `BCC_IDX_OPT: rd_word[`BCC_O_EACK] = early_ack_r;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ctrl_low_bits_zero;
    rd_idx == `BCC_IDX_CTRL |-> rd_word[`BCC_C_REPEAT_START_REQUEST] == 1'b0 && rd_word[0] == 1'b0;
  endproperty
  a_ctrl_low_bits_zero: assert property (p_ctrl_low_bits_zero)
    else $error("control read shows repeated start or reserved bit");
  property p_off_quiet;
    !module_on_r [*2] |-> !scl_oe && !sda_oe;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("pins driven while module disabled");
  property p_start_seq;
    state_r == ST_IDLE && module_on_r && master_select_r && !ms_prev_r && !arb_evt
      |=> state_r == ST_START_HI ##1 sda_oe && !scl_oe;
  endproperty
  a_start_seq: assert property (p_start_seq)
    else $error("no start after master select rose");
  property p_stop_seq;
    state_r == ST_MASTER && module_on_r && !master_select_r && !arb_evt
      |=> state_r == ST_STOP_LO ##1 sda_oe && scl_oe;
  endproperty
  a_stop_seq: assert property (p_stop_seq)
    else $error("no stop after master select fell");
  property p_arbitration_lost_flag_set;
    arb_lost_in && module_on_r |=> arbitration_lost_flag_r && !master_select_r;
  endproperty
  a_arbitration_lost_flag_set: assert property (p_arbitration_lost_flag_set)
    else $error("arbitration loss not flagged");
  property p_repeat_start_request_bad;
    repeat_start_request_req && state_r != ST_MASTER |=> arbitration_lost_flag_r && state_r == ST_IDLE;
  endproperty
  a_repeat_start_request_bad: assert property (p_repeat_start_request_bad)
    else $error("misplaced repeated start not treated as loss");
  property p_repeat_start_request_ok;
    repeat_start_request_ok && !arb_lost_in |=> state_r == ST_RS_SDA;
  endproperty
  a_repeat_start_request_ok: assert property (p_repeat_start_request_ok)
    else $error("repeated start not issued");
  property p_addressed_as_slave_flag_clr;
    any_ctrl_wr && !addr_match_in |=> !addressed_as_slave_flag_r;
  endproperty
  a_addressed_as_slave_flag_clr: assert property (p_addressed_as_slave_flag_clr)
    else $error("control write did not clear slave flag");
  property p_busy;
    module_on_r && start_det ##1 module_on_r |-> busy_r;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not set on start");
  property p_stretch;
    stretch_r && module_on_r && !wr_ctrl |=> stretch_r && scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock released before control write");
  property p_irq_gate;
    !irq_on_r |=> !irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");
  property p_wake;
    module_on_r && wake_r && low_power_in && addr_match_in |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on address match");

  c_start: cover property (state_r == ST_START_HI ##1 state_r == ST_START_HI);
  c_repeat_start_request: cover property (state_r == ST_RS_SDA);
  c_stop: cover property (state_r == ST_STOP_SDA ##1 state_r == ST_IDLE);
  c_stretch: cover property (stretch_r ##1 !stretch_r);
endmodule : bcc_ctrl

/* File: test/bcc_bus_peer.sv */
module bcc_bus_peer (
  input wire logic scl_oe, // block pulls clock low
  input wire logic sda_oe, // block pulls data low
  output logic scl, // wired clock line
  output logic sda // wired data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p_scl = 1'b0;
  logic p_sda = 1'b0;
  // open drain with pull-up: released lines float high
  assign scl = !(scl_oe || p_scl);
  assign sda = !(sda_oe || p_sda);
  // another master opens a frame, link clock runs only inside it
  task automatic start_c();
    p_sda = 1'b1;
    #62.5 p_scl = 1'b1;
    repeat (2) begin
      #62.5 p_scl = 1'b0;
      #62.5 p_scl = 1'b1;
    end
  endtask : start_c
  task automatic stop_c();
    #62.5 p_scl = 1'b0;
    #62.5 p_sda = 1'b0;
  endtask : stop_c
endmodule : bcc_bus_peer

/* File: test/tb.sv */
`include "bcc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_C = {3'h0, `BCC_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_S = {3'h0, `BCC_IDX_STAT, 2'h0};
  localparam logic [7:0] A_O = {3'h0, `BCC_IDX_OPT, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic scl, sda, scl_oe, sda_oe, irq_req, wake_req, master_mode, tx_mode;
  logic arb = 1'b0, match = 1'b0, slave_rw_indication = 1'b0, slot = 1'b0, rxd = 1'b0, act = 1'b0, lp = 1'b0;
  logic xd = 1'b0;
  int err_count = 0, cmp_count = 0;
  logic [31:0] d;
  logic [1:0] r;

  initial begin
    forever #2 aclk = ~aclk;
  end

  bcc_bus_peer u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  bcc_ctrl #(.PHASE_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_in(scl), .sda_in(sda), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .arb_lost_in(arb), .addr_match_in(match), .slave_rw_in(slave_rw_indication), .ack_slot_in(slot),
    .rx_byte_done_in(rxd), .byte_active_in(act), .xfer_done_in(xd), .low_power_in(lp),
    .irq_req(irq_req), .wake_req(wake_req), .master_mode(master_mode), .tx_mode(tx_mode));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic tmo();
    $display("BAD t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
    err_count++;
    results();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        r = bresp;
        break;
      end
    end
    if (n == 50) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (n == 50) tmo();
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & {24'h0, m}, {24'h0, e});
  endtask : rchk

  task automatic wait_mm(input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (master_mode === v) break;
    end
    if (n == 200) tmo();
  endtask : wait_mm

  task automatic ack_chk(input logic e);
    slot <= 1'b1;
    cyc(3);
    chk(sda_oe, e);
    slot <= 1'b0;
    cyc(2);
  endtask : ack_chk

  task automatic t_map();
    rchk(A_C, 8'hFF, `BCC_CTRL_RST);
    rd(8'h14);
    chk(r, `BCC_RESP_SLVERR);
    wr(8'h14, 8'hFF);
    chk(r, `BCC_RESP_SLVERR);
    wr(A_C, 8'h80);
    wr(A_C, 8'h87);
    rchk(A_C, 8'hFF, 8'h82);
    rchk(A_S, 8'h10, 8'h10);
    wr(A_S, 8'h10);
    rchk(A_S, 8'h10, 8'h00);
    arb <= 1'b1;
    cyc(1);
    arb <= 1'b0;
    rchk(A_S, 8'h10, 8'h10);
    wr(A_S, 8'h10);
    rchk(A_S, 8'h10, 8'h00);
    $display("test map done");
  endtask : t_map

  task automatic t_master();
    wr(A_C, 8'h90);
    wr(A_C, 8'hB0);
    wait_mm(1'b1);
    chk(tx_mode, 1'b1);
    rchk(A_S, 8'h21, 8'h21);
    wr(A_C, 8'hB4);
    cyc(40);
    chk(master_mode, 1'b1);
    rchk(A_C, 8'hFF, 8'hB0);
    rchk(A_S, 8'h10, 8'h00);
    act <= 1'b1;
    wr(A_C, 8'hB4);
    wait_mm(1'b0);
    rchk(A_S, 8'h10, 8'h10);
    act <= 1'b0;
    wr(A_S, 8'h10);
    wr(A_C, 8'hB0);
    wait_mm(1'b1);
    wr(A_C, 8'h90);
    wait_mm(1'b0);
    cyc(8);
    rchk(A_S, 8'h20, 8'h00);
    u_bus.start_c();
    rchk(A_S, 8'h21, 8'h20);
    u_bus.stop_c();
    cyc(8);
    rchk(A_S, 8'h20, 8'h00);
    $display("test master done");
  endtask : t_master

  task automatic t_ack();
    wr(A_C, 8'h80);
    rxd <= 1'b1;
    cyc(1);
    rxd <= 1'b0;
    cyc(3);
    chk(scl_oe, 1'b1);
    wr(A_C, 8'h80);
    cyc(2);
    chk(scl_oe, 1'b0);
    ack_chk(1'b1);
    wr(A_C, 8'h88);
    ack_chk(1'b1);
    ack_chk(1'b0);
    wr(A_O, 8'h01);
    wr(A_C, 8'h80);
    ack_chk(1'b1);
    wr(A_C, 8'h88);
    ack_chk(1'b0);
    wr(A_O, 8'h00);
    $display("test ack done");
  endtask : t_ack

  task automatic hit();
    slave_rw_indication <= 1'b1;
    match <= 1'b1;
    cyc(1);
    match <= 1'b0;
    cyc(4);
  endtask : hit

  task automatic t_slave();
    wr(A_C, 8'hC0);
    xd <= 1'b1;
    cyc(3);
    chk(irq_req, 1'b1);
    xd <= 1'b0;
    cyc(2);
    chk(irq_req, 1'b0);
    hit();
    chk(irq_req, 1'b1);
    rchk(A_S, 8'h44, 8'h44);
    wr(A_C, 8'hD0);
    rchk(A_S, 8'h40, 8'h00);
    chk(tx_mode, 1'b1);
    wr(A_C, 8'h80);
    hit();
    chk(irq_req, 1'b0);
    lp <= 1'b1;
    wr(A_C, 8'hC2);
    hit();
    chk(wake_req, 1'b1);
    lp <= 1'b0;
    wr(A_C, 8'hC0);
    lp <= 1'b1;
    hit();
    chk(wake_req, 1'b0);
    chk(irq_req, 1'b0);
    lp <= 1'b0;
    $display("test slave done");
  endtask : t_slave

  task automatic t_off();
    wr(A_C, 8'h00);
    wr(A_C, 8'h20);
    cyc(30);
    chk(master_mode, 1'b0);
    rxd <= 1'b1;
    cyc(1);
    rxd <= 1'b0;
    ack_chk(1'b0);
    chk(scl_oe, 1'b0);
    $display("test off done");
  endtask : t_off

  initial begin
    cyc(4);
    aresetn <= 1'b1;
    t_map();
    t_master();
    t_ack();
    t_slave();
    t_off();
    results();
  end
endmodule : tb
